// file: verilog/psn_host.sv
// Host controller driving the pseudo-SRAM style nonvolatile byte memory.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module psn_host (
    // Clock and reset.
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    // Power sequencing.
    input wire logic I_POWER_GOOD,
    input wire logic I_POWER_DOWN_REQ,
    output logic O_POWER_OFF_OK,
    // User request and answer.
    input wire logic I_REQ_VALID,
    input wire logic I_REQ_WRITE,
    input wire logic [psn_pkg::ADDR_W-1:0] I_REQ_ADDR,
    input wire logic [psn_pkg::DATA_W-1:0] I_REQ_WDATA,
    output logic O_REQ_READY,
    output logic O_RD_VALID,
    output logic [psn_pkg::DATA_W-1:0] O_RD_DATA,
    // Memory pins.
    output logic O_SELECT_LOW_N,
    output logic O_SELECT_HIGH,
    output logic O_WRITE_N,
    output logic O_OUTPUT_N,
    output logic [psn_pkg::ADDR_W-1:0] O_WORD_ADDRESS,
    input wire logic [psn_pkg::DATA_W-1:0] I_BYTE_LINES,
    output logic [psn_pkg::DATA_W-1:0] O_BYTE_LINES,
    output logic O_BYTE_LINES_OE
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum {
        ST_OFF, ST_POWERON, ST_IDLE, ST_SETUP, ST_ACTIVE, ST_HOLD, ST_PRECHARGE,
        ST_POWEROFF, ST_DOWN
    } psn_state_t;

    psn_state_t state_ff;
    psn_state_t nxt_state;
    logic [psn_pkg::CNT_W-1:0] cnt_ff;
    logic [psn_pkg::CNT_W-1:0] nxt_cnt;
    psn_pkg::psn_ctrl_t ctrl_ff;
    psn_pkg::psn_ctrl_t nxt_ctrl;
    psn_pkg::psn_req_t req_ff;
    psn_pkg::psn_req_t nxt_req;
    logic oe_ff;
    logic nxt_oe;
    logic ready_ff;
    logic nxt_ready;
    logic rd_valid_ff;
    logic nxt_rd_valid;
    logic [psn_pkg::DATA_W-1:0] rd_data_ff;
    logic [psn_pkg::DATA_W-1:0] nxt_rd_data;
    logic off_ok_ff;
    logic nxt_off_ok;
    logic pg_meta_ff;
    logic pg_ff;
    logic pd_meta_ff;
    logic pd_ff;
    logic [psn_pkg::DATA_W-1:0] byte_sync;

    function automatic logic [psn_pkg::CNT_W-1:0] cyc(input int n);
        return psn_pkg::CNT_W'(n - 1);
    endfunction

    psn_sync u_sync (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_d(I_BYTE_LINES),
        .o_q(byte_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Power status inputs pass two flops before use.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            pg_meta_ff <= 1'b0;
            pg_ff <= 1'b0;
            pd_meta_ff <= 1'b0;
            pd_ff <= 1'b0;
        end else begin
            pg_meta_ff <= I_POWER_GOOD;
            pg_ff <= pg_meta_ff;
            pd_meta_ff <= I_POWER_DOWN_REQ;
            pd_ff <= pd_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer: select_low_n and the strobe fall together with the
    // address already stable, so every documented latch edge sees valid values.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_ctrl = ctrl_ff;
        nxt_req = req_ff;
        nxt_oe = oe_ff;
        nxt_ready = 1'b0;
        nxt_rd_valid = 1'b0;
        nxt_rd_data = rd_data_ff;
        nxt_off_ok = off_ok_ff;
        case (state_ff)
            ST_OFF: begin
                nxt_ctrl = psn_pkg::CTRL_IDLE;
                nxt_oe = 1'b0;
                if (pg_ff) begin
                    nxt_state = ST_POWERON;
                    nxt_cnt = cyc(psn_pkg::POWERON_SELECT_HOLD_CYC);
                end
            end
            ST_POWERON: begin
                if (!pg_ff) begin
                    nxt_state = ST_OFF;
                end else if (cnt_ff == psn_pkg::CNT_ZERO) begin
                    nxt_state = ST_IDLE;
                    nxt_ctrl.select_high = 1'b1;
                    nxt_ready = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            ST_IDLE: begin
                nxt_ready = 1'b1;
                if (pd_ff || !pg_ff) begin
                    nxt_ready = 1'b0;
                    nxt_state = ST_POWEROFF;
                    nxt_ctrl = psn_pkg::CTRL_IDLE;
                    nxt_cnt = cyc(psn_pkg::POWEROFF_SELECT_HOLD_CYC);
                end else if (I_REQ_VALID && ready_ff) begin
                    nxt_ready = 1'b0;
                    nxt_req.write = I_REQ_WRITE;
                    nxt_req.addr = I_REQ_ADDR;
                    nxt_req.wdata = I_REQ_WDATA;
                    nxt_oe = I_REQ_WRITE;
                    nxt_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Address and data are on the pins one cycle before the strobes fall.
                nxt_ctrl.select_low_n = 1'b0;
                nxt_ctrl.write_n = !req_ff.write;
                nxt_ctrl.output_n = req_ff.write;
                nxt_cnt = cyc(psn_pkg::ACTIVE_CYC);
                nxt_state = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                if (cnt_ff == psn_pkg::CNT_ZERO) begin
                    if (!req_ff.write) begin
                        nxt_rd_data = byte_sync;
                        nxt_rd_valid = 1'b1;
                    end
                    nxt_ctrl.select_low_n = 1'b1;
                    nxt_ctrl.write_n = 1'b1;
                    nxt_ctrl.output_n = 1'b1;
                    nxt_cnt = cyc(psn_pkg::HOLD_CYC);
                    nxt_state = ST_HOLD;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            ST_HOLD: begin
                // Address and data held after the strobes rise; precharge follows in ST_PRECHARGE.
                if (cnt_ff == psn_pkg::CNT_ZERO) begin
                    nxt_oe = 1'b0;
                    nxt_cnt = cyc(psn_pkg::PRECHARGE_CYC);
                    nxt_state = ST_PRECHARGE;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            ST_PRECHARGE: begin
                if (cnt_ff == psn_pkg::CNT_ZERO) begin
                    nxt_state = ST_IDLE;
                    nxt_ready = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            ST_POWEROFF: begin
                if (cnt_ff == psn_pkg::CNT_ZERO) begin
                    nxt_state = ST_DOWN;
                    nxt_off_ok = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            ST_DOWN: begin
                if (!pg_ff) begin
                    nxt_off_ok = 1'b0;
                    nxt_state = ST_OFF;
                end
            end
            default: begin
                nxt_state = ST_OFF;
                nxt_ctrl = psn_pkg::CTRL_IDLE;
                nxt_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            state_ff <= ST_OFF;
            cnt_ff <= psn_pkg::CNT_ZERO;
            ctrl_ff <= psn_pkg::CTRL_IDLE;
            req_ff <= '0;
            oe_ff <= 1'b0;
            ready_ff <= 1'b0;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= psn_pkg::DATA_RST;
            off_ok_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ctrl_ff <= nxt_ctrl;
            req_ff <= nxt_req;
            oe_ff <= nxt_oe;
            ready_ff <= nxt_ready;
            rd_valid_ff <= nxt_rd_valid;
            rd_data_ff <= nxt_rd_data;
            off_ok_ff <= nxt_off_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign O_SELECT_LOW_N = ctrl_ff.select_low_n;
    assign O_SELECT_HIGH = ctrl_ff.select_high;
    assign O_WRITE_N = ctrl_ff.write_n;
    assign O_OUTPUT_N = ctrl_ff.output_n;
    assign O_WORD_ADDRESS = req_ff.addr;
    assign O_BYTE_LINES = req_ff.wdata;
    assign O_BYTE_LINES_OE = oe_ff;
    assign O_REQ_READY = ready_ff;
    assign O_RD_VALID = rd_valid_ff;
    assign O_RD_DATA = rd_data_ff;
    assign O_POWER_OFF_OK = off_ok_ff;
endmodule

// file: verilog/psn_pkg.sv
// Package with pin-side constants, timing counts and carrier types of the host port.
package psn_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CLK_NS = 40;
    // Least times in ns, rounded up to whole cycles below.
    localparam int T_ACTIVE_NS = 120;
    localparam int T_PRECHARGE_NS = 20;
    localparam int T_HOLD_NS = 50;
    localparam int T_POWER_NS = 85;
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int ACTIVE_CYC = ceil_cyc(T_ACTIVE_NS);
    localparam int PRECHARGE_CYC = ceil_cyc(T_PRECHARGE_NS);
    localparam int HOLD_CYC = ceil_cyc(T_HOLD_NS);
    localparam int POWERON_SELECT_HOLD_CYC = ceil_cyc(T_POWER_NS);
    localparam int POWEROFF_SELECT_HOLD_CYC = ceil_cyc(T_POWER_NS);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef struct packed {
        logic select_low_n;
        logic select_high;
        logic write_n;
        logic output_n;
    } psn_ctrl_t;

    localparam psn_ctrl_t CTRL_IDLE = '{select_low_n: 1'b1, select_high: 1'b0,
                                        write_n: 1'b1, output_n: 1'b1};

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } psn_req_t;
endpackage

// file: verilog/psn_sync.sv
// Two-flop synchroniser for the byte lines coming back from the memory.
`timescale 1ns/1ps
module psn_sync (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Asynchronous input and synchronised output.
    input wire logic [psn_pkg::DATA_W-1:0] i_d,
    output logic [psn_pkg::DATA_W-1:0] o_q
);
    logic [psn_pkg::DATA_W-1:0] meta_ff;
    logic [psn_pkg::DATA_W-1:0] sync_ff;
    logic [psn_pkg::DATA_W-1:0] nxt_meta;
    logic [psn_pkg::DATA_W-1:0] nxt_sync;

    always_comb begin
        nxt_meta = i_d;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_ff <= psn_pkg::DATA_RST;
            sync_ff <= psn_pkg::DATA_RST;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_q = sync_ff;
endmodule

// file: bench/psn_host_monitor.sv
// Checker of the pin sequence driven by the host controller.
`timescale 1ns/1ps
module psn_host_monitor (
    // Clock, reset and user side.
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_REQ_VALID,
    input wire logic O_REQ_READY,
    input wire logic O_POWER_OFF_OK,
    // Memory pins.
    input wire logic O_SELECT_LOW_N,
    input wire logic O_SELECT_HIGH,
    input wire logic O_WRITE_N,
    input wire logic O_OUTPUT_N,
    input wire logic [psn_pkg::ADDR_W-1:0] O_WORD_ADDRESS,
    input wire logic [psn_pkg::DATA_W-1:0] O_BYTE_LINES,
    input wire logic O_BYTE_LINES_OE
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    property p_off_idle;
        O_POWER_OFF_OK |-> O_SELECT_LOW_N && !O_SELECT_HIGH;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("enable on while off");
    property p_off_hold;
        $rose(O_POWER_OFF_OK) |-> $past(O_SELECT_LOW_N, 3) && $past(O_SELECT_LOW_N, 2);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("short off hold");
    property p_on_hold;
        $fell(O_SELECT_LOW_N) |-> $past(O_SELECT_LOW_N, 3) && $past(O_SELECT_LOW_N, 2);
    endproperty
    a_on_hold: assert property (p_on_hold) else $error("short enable gap");
    property p_read_strobe;
        $fell(O_OUTPUT_N) |-> (!O_OUTPUT_N && O_WRITE_N && !O_BYTE_LINES_OE)[*3] ##1 O_OUTPUT_N;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("bad read strobe");
    property p_write_strobe;
        $fell(O_WRITE_N) |-> (!O_WRITE_N && O_OUTPUT_N && O_BYTE_LINES_OE)[*3] ##1 O_WRITE_N;
    endproperty
    a_write_strobe: assert property (p_write_strobe) else $error("bad write strobe");
    property p_selected;
        !(O_OUTPUT_N && O_WRITE_N) |-> !O_SELECT_LOW_N && O_SELECT_HIGH;
    endproperty
    a_selected: assert property (p_selected) else $error("strobe unselected");
    property p_rd_addr;
        $fell(O_OUTPUT_N) |-> ##1 $stable(O_WORD_ADDRESS)[*5];
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("read address moved");
    property p_wr_hold;
        $fell(O_WRITE_N) |-> ##1 $stable({O_WORD_ADDRESS, O_BYTE_LINES})[*4];
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write value moved");
    // Ready stays low for setup, three strobe cycles, two hold cycles and one precharge.
    property p_take;
        I_REQ_VALID && O_REQ_READY |=> (!O_REQ_READY)[*7] ##1 O_REQ_READY;
    endproperty
    a_take: assert property (p_take) else $error("bad request spacing");
endmodule
bind psn_host psn_host_monitor u_mon (.I_CORE_CLK, .I_RST, .I_REQ_VALID, .O_REQ_READY,
    .O_POWER_OFF_OK, .O_SELECT_LOW_N, .O_SELECT_HIGH, .O_WRITE_N, .O_OUTPUT_N,
    .O_WORD_ADDRESS, .O_BYTE_LINES, .O_BYTE_LINES_OE);

// file: bench/psn_mem_model.sv
// Behavioural model of the byte-wide nonvolatile memory at its pins.
`timescale 1ns/1ps
module psn_mem_model (
    // Enables and strobes.
    input wire logic i_select_low_n,
    input wire logic i_select_high,
    input wire logic i_write_n,
    input wire logic i_output_n,
    // Address and byte lines.
    input wire logic [psn_pkg::ADDR_W-1:0] i_word_address,
    input wire logic [psn_pkg::DATA_W-1:0] i_byte_lines,
    output logic [psn_pkg::DATA_W-1:0] o_byte_lines
);
    logic [psn_pkg::DATA_W-1:0] mem [0:524287];
    logic [psn_pkg::ADDR_W-1:0] addr_lat;
    logic [psn_pkg::DATA_W-1:0] last = 8'h5a;
    logic access;
    logic drive;
    assign access = !i_select_low_n && i_select_high && !(i_write_n && i_output_n);
    assign drive = access && i_write_n && !i_output_n;
    // Address and write data are caught at the edge that starts the access.
    always @(posedge access) begin
        addr_lat = i_word_address;
        if (!i_write_n) begin
            mem[i_word_address] = i_byte_lines;
        end
    end
    // A released bus shows the inverse of its last value.
    always @(drive or addr_lat) begin
        if (drive) begin
            last = mem[addr_lat];
        end
        o_byte_lines = drive ? last : ~last;
    end
endmodule

// file: bench/test_pseudo_sram_nvram_port.sv
// Testbench of the host controller against the memory model.
`timescale 1ns/1ps
module test_pseudo_sram_nvram_port;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pgood = 1'b0;
    logic pdown = 1'b0;
    logic valid = 1'b0;
    psn_pkg::psn_req_t req = '0;
    logic off_ok, ready, rd_valid, sel_n, sel_h, wr_n, out_n, oe;
    logic [7:0] rd_data, dout, mdl_q, bus;
    logic [18:0] addr;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    assign bus = oe ? dout : mdl_q;
    psn_host u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_POWER_GOOD(pgood),
        .I_POWER_DOWN_REQ(pdown), .O_POWER_OFF_OK(off_ok), .I_REQ_VALID(valid),
        .I_REQ_WRITE(req.write), .I_REQ_ADDR(req.addr), .I_REQ_WDATA(req.wdata),
        .O_REQ_READY(ready), .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data),
        .O_SELECT_LOW_N(sel_n), .O_SELECT_HIGH(sel_h), .O_WRITE_N(wr_n),
        .O_OUTPUT_N(out_n), .O_WORD_ADDRESS(addr), .I_BYTE_LINES(bus),
        .O_BYTE_LINES(dout), .O_BYTE_LINES_OE(oe));
    psn_mem_model u_mem (.i_select_low_n(sel_n), .i_select_high(sel_h), .i_write_n(wr_n),
        .i_output_n(out_n), .i_word_address(addr), .i_byte_lines(bus), .o_byte_lines(mdl_q));
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_ready();
        int n = 0;
        while (ready !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        check("ready", ready, 1);
    endtask
    task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] d,
        input logic [7:0] exp);
        int n = 0;
        wait_ready();
        req = '{write: wr, addr: a, wdata: d};
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        if (!wr) begin
            while (rd_valid !== 1'b1 && n < 10) begin
                @(negedge clk);
                n++;
            end
            // Read data arrives one setup cycle plus the strobe cycles after the take.
            check("read byte", rd_data, exp);
            check("read delay", n, psn_pkg::ACTIVE_CYC + 1);
        end
    endtask
    task automatic t_rw();
        logic [18:0] a [3] = '{19'h00000, 19'h7ffff, 19'h12345};
        logic [7:0] d [3] = '{8'ha5, 8'h3c, 8'h81};
        for (int i = 0; i < 3; i++) begin
            access(1'b1, a[i], d[i], 8'h00);
        end
        for (int i = 0; i < 3; i++) begin
            check("stored byte", u_mem.mem[a[i]], d[i]);
            access(1'b0, a[i], 8'h00, d[i]);
        end
    endtask
    task automatic t_refused();
        access(1'b1, 19'h00200, 8'h77, 8'h00);
        req = '{write: 1'b1, addr: 19'h00200, wdata: 8'h22};
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        access(1'b0, 19'h00200, 8'h00, 8'h77);
    endtask
    task automatic t_power();
        int n = 0;
        wait_ready();
        pdown = 1'b1;
        while (off_ok !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("off ok", off_ok, 1);
        check("enables", {sel_n, sel_h}, 2'b10);
        pgood = 1'b0;
        pdown = 1'b0;
        repeat (6) @(negedge clk);
        check("off ok clear", off_ok, 0);
        check("enables off", {sel_n, sel_h}, 2'b10);
        pgood = 1'b1;
        // Two synchroniser cycles, one entry cycle, then the power-on hold.
        n = 0;
        while (ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("power-on wait", n, psn_pkg::POWERON_SELECT_HOLD_CYC + 3);
        access(1'b0, 19'h7ffff, 8'h00, 8'h3c);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        pgood = 1'b1;
        t_rw();
        t_refused();
        t_power();
        final_report();
    end
endmodule
